// ==== hdl/zcd_pkg.sv ====
// constants for the zero current detect and carrier select block
package zcd_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam logic [15:0] DISABLE_CODE = 16'h270F;      // 9999 disables
  localparam logic [7:0] LEVEL_MAX_PCT = 8'h32;         // 50 %
  localparam logic [7:0] LEVEL_RESET_PCT = 8'h37;       // 55 %
  localparam logic [7:0] LEVEL_FULL_PCT = 8'h64;        // 100 % = rated
  localparam logic [15:0] TIME_MIN_MS = 16'h0032;       // 0.05 s
  localparam logic [15:0] TIME_MAX_MS = 16'h03E8;       // 1 s
  localparam logic [15:0] DEV_MAX_RPM = 16'h05DC;       // 1500 r/min
  localparam logic [7:0] TERM_FUNC_OPEN = 8'h07;
  localparam logic [2:0] CARRIER_MAX = 3'h6;
  localparam logic [2:0] CARRIER_RESET = 3'h0;
  localparam logic [9:0] WP_TUNE_CODE = 10'h321;        // 801
  localparam logic [9:0] WP_RESET = 10'h000;
  localparam logic [5:0] TUNE_FIRST = 6'h29;            // slot 41
  localparam logic [5:0] TUNE_LAST = 6'h2F;             // slot 47
  localparam logic [15:0] TUNE_RESET = 16'h270F;
  localparam int MS_NS = 1_000_000;
  localparam int CLK_NS = 5;
  localparam int HOLD_MS = 100;
  localparam int LATENCY_MS = 10;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int HOLD_CYCLES = HOLD_MS * MS_CYCLES;
endpackage

// ==== hdl/zcd_block.sv ====
// zero current detection, open circuit output and carrier/tuning settings
`timescale 1ns/1ps
module zcd_block
  import zcd_pkg::*;
#(
  parameter int MS_CYC = zcd_pkg::MS_CYCLES,
  parameter int HOLD_CYC = zcd_pkg::HOLD_CYCLES
)(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic motor_running_i,
  input wire logic [7:0] current_pct_i,
  input wire logic param_we_i,
  input wire logic [5:0] param_slot_i,
  input wire logic [15:0] param_wdata_i,
  input wire logic [5:0] param_rslot_i,
  output logic [15:0] param_rdata_o,
  output logic tune_access_o,
  output logic open_circuit_o,
  output logic zero_current_output_terminal_o,
  output logic coast_o,
  output logic speed_deviation_fault_o,
  output logic [2:0] carrier_select_o,
  output logic [15:0] tuned_const_o [7]
);
  import zcd_pkg::*;

  // parameter slot numbers chosen for the local settings
  localparam logic [5:0] SLOT_LEVEL = 6'h01;
  localparam logic [5:0] SLOT_TIME = 6'h02;
  localparam logic [5:0] SLOT_DEV = 6'h03;
  localparam logic [5:0] SLOT_FUNC = 6'h04;
  localparam logic [5:0] SLOT_CARRIER = 6'h05;
  localparam logic [5:0] SLOT_WP = 6'h06;
  localparam int TUNE_N = int'(TUNE_LAST) - int'(TUNE_FIRST) + 1;

  typedef enum logic [2:0] {
    ZCD_IDLE = 3'b001,
    ZCD_LOW = 3'b010,
    ZCD_HOLD = 3'b100
  } zcd_state_e;

  function automatic logic is_tune_slot(input logic [5:0] s);
    is_tune_slot = (s >= TUNE_FIRST) && (s <= TUNE_LAST);
  endfunction

  logic [7:0] zero_current_level;
  logic [15:0] zero_current_time;
  logic [15:0] speed_deviation_level;
  logic [7:0] output_terminal_function;
  logic [2:0] carrier_select;
  logic [9:0] write_protect_select;
  // power-up contents stand for the factory values
  logic [15:0] tune_pending [7] = '{default: TUNE_RESET};
  logic [15:0] tune_active [7];
  logic tune_mode;
  logic wr_tune;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  zcd_state_e state;
  logic [31:0] cyc_cnt;
  logic [15:0] ms_cnt;
  logic below;
  logic detect_en;

  assign tune_mode = (write_protect_select == WP_TUNE_CODE);
  assign wr_tune = param_we_i && tune_mode && is_tune_slot(param_slot_i);
  assign wr_idx = 3'(param_slot_i - TUNE_FIRST);
  assign rd_idx = 3'(param_rslot_i - TUNE_FIRST);
  // level is percent of rated current, compared directly
  assign below = current_pct_i < zero_current_level;
  assign detect_en = zero_current_time != DISABLE_CODE;
  assign tune_access_o = tune_mode;

  ////////////////////////////////////////////////////////////////////////
  // settings; out of range level, time, deviation and carrier writes are ignored
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      zero_current_level <= LEVEL_RESET_PCT;
      zero_current_time <= DISABLE_CODE;
      speed_deviation_level <= DISABLE_CODE;
      output_terminal_function <= 8'h00;
      carrier_select <= CARRIER_RESET;
      write_protect_select <= WP_RESET;
    end
    else if (param_we_i && !is_tune_slot(param_slot_i))
    begin
      case (param_slot_i)
        SLOT_LEVEL:
          if (param_wdata_i <= 16'(LEVEL_MAX_PCT))
            zero_current_level <= param_wdata_i[7:0];
        SLOT_TIME:
          if (param_wdata_i == DISABLE_CODE
              || (param_wdata_i >= TIME_MIN_MS && param_wdata_i <= TIME_MAX_MS))
            zero_current_time <= param_wdata_i;
        SLOT_DEV:
          if (param_wdata_i == DISABLE_CODE || param_wdata_i <= DEV_MAX_RPM)
            speed_deviation_level <= param_wdata_i;
        SLOT_FUNC:
          output_terminal_function <= param_wdata_i[7:0];
        SLOT_CARRIER:
          // stopping first is left to the operator
          if (param_wdata_i <= 16'(CARRIER_MAX))
            carrier_select <= param_wdata_i[2:0];
        SLOT_WP:
          write_protect_select <= param_wdata_i[9:0];
        default:
          zero_current_level <= zero_current_level;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tuned constants: written to a shadow, applied only at reset
  // the shadow has no reset, otherwise a drive reset would wipe what it must apply
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_tune)
      tune_pending[wr_idx] <= param_wdata_i;
  end

  // active copies the shadow once, at the first edge after reset release
  logic tune_load;
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tune_load <= 1'b1;
    else
      tune_load <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < TUNE_N; i++)
        tune_active[i] <= TUNE_RESET;
    end
    else if (tune_load)
      tune_active <= tune_pending;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      param_rdata_o <= 16'h0000;
    else if (tune_mode && is_tune_slot(param_rslot_i))
      param_rdata_o <= tune_pending[rd_idx];
    else
      case (param_rslot_i)
        SLOT_LEVEL: param_rdata_o <= 16'(zero_current_level);
        SLOT_TIME: param_rdata_o <= zero_current_time;
        SLOT_DEV: param_rdata_o <= speed_deviation_level;
        SLOT_FUNC: param_rdata_o <= 16'(output_terminal_function);
        SLOT_CARRIER: param_rdata_o <= 16'(carrier_select);
        SLOT_WP: param_rdata_o <= 16'(write_protect_select);
        default: param_rdata_o <= 16'h0000;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // detection timer; ms prescaler keeps ms_cnt narrow, the hold counts raw cycles in cyc_cnt
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= ZCD_IDLE;
      cyc_cnt <= 32'h0;
      ms_cnt <= 16'h0;
    end
    else
    begin
      case (state)
        ZCD_IDLE:
        begin
          cyc_cnt <= 32'h0;
          ms_cnt <= 16'h0;
          if (motor_running_i && detect_en && below)
            state <= ZCD_LOW;
        end
        ZCD_LOW:
          if (!motor_running_i || !detect_en || !below)
            state <= ZCD_IDLE;
          else if (ms_cnt >= zero_current_time)
          begin
            state <= ZCD_HOLD;
            cyc_cnt <= 32'h0;
          end
          else if (cyc_cnt == 32'(MS_CYC - 1))
          begin
            cyc_cnt <= 32'h0;
            ms_cnt <= ms_cnt + 16'h1;
          end
          else
            cyc_cnt <= cyc_cnt + 32'h1;
        ZCD_HOLD:
          if (!detect_en)
            state <= ZCD_IDLE;
          else if (below && motor_running_i)
            cyc_cnt <= 32'h0;
          else if (cyc_cnt == 32'(HOLD_CYC - 1))
            state <= ZCD_IDLE;
          else
            cyc_cnt <= cyc_cnt + 32'h1;
        default:
          state <= ZCD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      open_circuit_o <= 1'b0;
      zero_current_output_terminal_o <= 1'b0;
      coast_o <= 1'b0;
      speed_deviation_fault_o <= 1'b0;
    end
    else
    begin
      open_circuit_o <= state == ZCD_HOLD;
      zero_current_output_terminal_o <= (state == ZCD_HOLD)
        && (output_terminal_function == TERM_FUNC_OPEN);
      // fault latches until reset, like any drive trip
      if (state == ZCD_HOLD && speed_deviation_level != DISABLE_CODE)
      begin
        coast_o <= 1'b1;
        speed_deviation_fault_o <= 1'b1;
      end
    end
  end

  assign carrier_select_o = carrier_select;
  assign tuned_const_o = tune_active;
endmodule

// ==== testbench/zcd_chk.sv ====
// assertion checker for the zero current detect block
`timescale 1ns/1ps
module zcd_chk
  import zcd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic motor_running_i,
  input wire logic param_we_i,
  input wire logic [5:0] param_slot_i,
  input wire logic [15:0] param_wdata_i,
  input wire logic [5:0] param_rslot_i,
  input wire logic [15:0] param_rdata_o,
  input wire logic tune_access_o,
  input wire logic open_circuit_o,
  input wire logic zero_current_output_terminal_o,
  input wire logic coast_o,
  input wire logic speed_deviation_fault_o,
  input wire logic [2:0] carrier_select_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  term_gate_a: assert property (zero_current_output_terminal_o |-> open_circuit_o || $past(open_circuit_o))
    else $error("terminal on without indication");
  carrier_range_a: assert property (carrier_select_o <= CARRIER_MAX)
    else $error("carrier code out of range");
  fault_sticky_a: assert property (speed_deviation_fault_o |=> speed_deviation_fault_o && coast_o)
    else $error("fault or coast dropped");
  fault_open_a: assert property ($rose(speed_deviation_fault_o) |-> ##[0:1] open_circuit_o)
    else $error("fault without indication");
  run_needed_a: assert property ($rose(open_circuit_o) |-> $past(motor_running_i, 2))
    else $error("indication while stopped");
  hold_min_a: assert property ($rose(open_circuit_o) ##0 motor_running_i[*8] |-> open_circuit_o)
    else $error("indication released early");
  tune_gate_a: assert property ($past(param_rslot_i) inside {[TUNE_FIRST:TUNE_LAST]}
    && !$past(tune_access_o) |-> param_rdata_o == 16'h0000)
    else $error("tuned slot readable while locked");
  tune_open_a: assert property (param_we_i && param_slot_i == 6'h06
    && param_wdata_i == {6'h00, WP_TUNE_CODE} |=> tune_access_o)
    else $error("tuned access not opened");
endmodule
bind zcd_block zcd_chk u_chk (.clk_sys_i, .rstn_i, .motor_running_i, .param_we_i, .param_slot_i,
  .param_wdata_i, .param_rslot_i, .param_rdata_o, .tune_access_o, .open_circuit_o,
  .zero_current_output_terminal_o, .coast_o, .speed_deviation_fault_o, .carrier_select_o);

// ==== testbench/zcd_plant.sv ====
// behavioural power stage and current sense
`timescale 1ns/1ps
module zcd_plant (
  input wire logic clk_sys_i,
  input wire logic run_i,
  input wire logic [7:0] load_i,
  output logic running_o,
  output logic [7:0] pct_o
);
  initial running_o = 1'b0;
  initial pct_o = 8'h00;
  // a stopped stage carries no current
  always @(negedge clk_sys_i)
  begin
    running_o <= run_i;
    pct_o <= run_i ? load_i : 8'h00;
  end
endmodule

// ==== testbench/zcd_block_tb_top.sv ====
// self-checking bench for the zero current detect block
`timescale 1ns/1ps
module zcd_block_tb_top;
  import zcd_pkg::*;
  localparam int MS = 4;
  localparam int HOLD = 20;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic run = 1'b0;
  logic we = 1'b0;
  logic [7:0] load = 8'h00;
  logic [5:0] slot = 6'h00;
  logic [5:0] rslot = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic running, oc, term, coast, fault, tacc;
  logic [7:0] pct, lvl;
  logic [15:0] rdata, rv, v;
  logic [2:0] car;
  logic [15:0] tc [7];
  logic [15:0] tv [7];
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  zcd_plant plant (.clk_sys_i, .run_i(run), .load_i(load), .running_o(running), .pct_o(pct));
  zcd_block #(.MS_CYC(MS), .HOLD_CYC(HOLD)) dut (.clk_sys_i, .rstn_i, .motor_running_i(running),
    .current_pct_i(pct), .param_we_i(we), .param_slot_i(slot), .param_wdata_i(wdata),
    .param_rslot_i(rslot), .param_rdata_o(rdata), .tune_access_o(tacc), .open_circuit_o(oc),
    .zero_current_output_terminal_o(term), .coast_o(coast), .speed_deviation_fault_o(fault),
    .carrier_select_o(car), .tuned_const_o(tc));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int det_cyc(input int ms);
    return ms * MS + 2;
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [5:0] s, input logic [15:0] d);
    @(negedge clk_sys_i);
    we = 1'b1;
    slot = s;
    wdata = d;
    @(negedge clk_sys_i);
    we = 1'b0;
  endtask
  task rd(input logic [5:0] s);
    @(negedge clk_sys_i);
    rslot = s;
    @(negedge clk_sys_i);
    rv = rdata;
  endtask
  // bounded wait on the indication, n counts falling edges
  task wait_oc(input logic val);
    n = 0;
    while (oc !== val)
    begin
      @(negedge clk_sys_i);
      n++;
      if (n > 2000)
      begin
        n_errors++;
        test_done;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hA72948DE));
    repeat (3) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    rd(6'h01);
    chk(rv, {8'h00, LEVEL_RESET_PCT});
    wr(6'h01, {8'h00, LEVEL_MAX_PCT});
    wr(6'h03, 16'($urandom % 1501));
    run <= 1'b1;
    repeat (400) @(negedge clk_sys_i);
    chk(16'({oc, fault}), 16'h0000);
    run <= 1'b0;
    for (int i = 0; i <= 7; i++)
    begin
      wr(6'h05, 16'(i));
      chk(16'(car), 16'(i > 6 ? 6 : i));
    end
    rd(TUNE_FIRST);
    chk(rv, 16'h0000);
    wr(6'h06, {6'h00, WP_TUNE_CODE});
    for (int i = 0; i < 7; i++)
    begin
      v = 16'($urandom);
      tv[i] = v;
      wr(TUNE_FIRST + 6'(i), v);
      rd(TUNE_FIRST + 6'(i));
      chk(rv, v);
      chk(tc[i], TUNE_RESET);
    end
    wr(6'h06, 16'($urandom % 3));
    chk(16'(tacc), 16'h0000);
    wr(6'h01, 16'h0033);
    wr(6'h02, 16'h0031);
    rd(6'h01);
    chk(rv, 16'h0032);
    rd(6'h02);
    chk(rv, DISABLE_CODE);
    wr(6'h02, TIME_MIN_MS);
    lvl = 8'(1 + $urandom % 50);
    wr(6'h01, {8'h00, lvl});
    run <= 1'b1;
    load <= 8'($urandom % lvl);
    // a sample at level part way must restart the timer
    repeat (150) @(negedge clk_sys_i);
    load <= lvl;
    repeat (3) @(negedge clk_sys_i);
    chk(16'(oc), 16'h0000);
    load <= 8'($urandom % lvl);
    wait_oc(1'b1);
    chk(16'(n >= det_cyc(50) - 2 && n <= det_cyc(50) + 3), 16'h0001);
    chk(16'({fault, coast, term}), 16'h0006);
    wr(6'h04, {8'h00, TERM_FUNC_OPEN});
    @(negedge clk_sys_i);
    chk(16'(term), 16'h0001);
    load <= lvl;
    wait_oc(1'b0);
    chk(16'(n >= HOLD && n <= HOLD + 5), 16'h0001);
    // drive reset in mid-run: written constants now take effect
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    @(negedge clk_sys_i);
    for (int i = 0; i < 7; i++)
      chk(tc[i], tv[i]);
    chk(16'({fault, coast, oc}), 16'h0000);
    rd(6'h01);
    chk(rv, {8'h00, LEVEL_RESET_PCT});
    test_done;
  end
endmodule
